// [rtl/dlat_pkg.sv]
package dlat_pkg;
    // logical geometry seen by the channel program
    localparam logic [7:0] DLAT_LCYL_MAX = 8'hd1;
    localparam logic [4:0] DLAT_LHEAD_MAX = 5'h13;
    localparam logic [14:0] DLAT_LTRK_PER_CYL = 15'h014;
    localparam logic [14:0] DLAT_VOL_TRACKS = 15'h1068;
    // physical geometry of the two drive kinds
    localparam logic [4:0] DLAT_RM_HEADS = 5'h0c;
    localparam logic [4:0] DLAT_FX_HEADS = 5'h1e;
    localparam logic [9:0] DLAT_RM_POS = 10'h15e;
    localparam logic [9:0] DLAT_FX_POS = 10'h230;
    // microcode cylinders: six heads each, two or five per position
    localparam logic [4:0] DLAT_UC_HEADS = 5'h06;
    localparam logic [11:0] DLAT_UC_RM_PER_POS = 12'h002;
    localparam logic [11:0] DLAT_UC_FX_PER_POS = 12'h005;
    localparam logic [11:0] DLAT_UC_FX_CYLS = 12'h2bc;
    // record numbering limits
    localparam logic [7:0] DLAT_MAX_REC = 8'h64;
    localparam logic [7:0] DLAT_HALF_MAX = 8'h32;
    localparam logic [6:0] DLAT_SLOT_HOME = 7'h00;
    localparam logic [6:0] DLAT_SLOT_DESC = 7'h01;
    // halftrack capacity figures in bytes
    localparam logic [13:0] DLAT_HALF_CAP = 14'h2157;
    localparam logic [16:0] DLAT_OVH_NOKEY = 17'h000a7;
    localparam logic [16:0] DLAT_OVH_KEY = 17'h000f2;
    localparam logic [1:0] DLAT_CMD_W = 2'h2;

    typedef enum logic [1:0] {
        DLAT_CMD_DATA,
        DLAT_CMD_HOME,
        DLAT_CMD_DESC
    } dlat_cmd_e;

    typedef enum {
        DLAT_CAP_IDLE,
        DLAT_CAP_RUN
    } dlat_cap_state_e;
endpackage : dlat_pkg

// [rtl/dlat_translator.sv]
`timescale 1ns/1ps
// Functional notes
// - logical cylinders 00 to d1, 210 in all; higher ones are refused
// - each logical cylinder holds 20 logical tracks
// - logical heads 00 to 13 per cylinder; higher ones are refused
// - removable module: 12 heads, logical cylinder overflows into next
// - each halftrack starts with home address then descriptor record
// - records numbered across the whole track from the even descriptor
// - one defective halftrack needs both flagged, both to one alternate
// - removable module has 350 access positions
// - removable module: 12 tracks per access position
// - fixed drive: 560 positions, 30 tracks each
// - at most 102 records per track, both descriptors included
// - home address and descriptor selected by their own commands
// - translation of logical to physical address is done in hardware
// - microcode track is a halftrack, parity picks the index marker
// - microcode cylinders: two per removable, five per fixed position
// - a record stays wholly inside one halftrack
// - records per halftrack = 8535 / (overhead + key + data)
// - overhead is 167 without key, 242 with key
module dlat_translator (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic req_in,
    input wire dlat_pkg::dlat_cmd_e cmd_in,
    input wire logic fixed_drive_in,
    input wire logic [1:0] volume_in,
    input wire logic [7:0] lcyl_in,
    input wire logic [4:0] lhead_in,
    input wire logic [7:0] record_in,
    input wire logic odd_half_sel_in,
    input wire logic [7:0] even_last_rec_in,
    input wire logic even_defect_in,
    input wire logic odd_defect_in,
    input wire logic [9:0] alt_pcyl_in,
    input wire logic [4:0] alt_phead_in,
    input wire logic cap_start_in,
    input wire logic [7:0] key_length_bytes_in,
    input wire logic [15:0] data_length_bytes_in,
    output logic done_out,
    output logic [9:0] pcyl_out,
    output logic [4:0] phead_out,
    output logic odd_half_out,
    output logic [6:0] slot_out,
    output logic alt_used_out,
    output logic addr_err_out,
    output logic alt_err_out,
    output logic [11:0] uc_cyl_out,
    output logic [15:0] uc_track_out,
    output logic cap_busy_out,
    output logic cap_done_out,
    output logic [5:0] cap_records_out
);
    import dlat_pkg::*;

    logic [14:0] next_lin;
    logic [4:0] heads;
    logic [9:0] positions;
    logic [9:0] next_pcyl;
    logic [4:0] next_phead;
    logic next_odd;
    logic [6:0] next_slot;
    logic next_alt;
    logic next_addr_err;
    logic next_alt_err;
    logic [11:0] next_uc_cyl;
    logic [15:0] next_uc_track;
    logic [7:0] odd_index;
    logic [15:0] phys_trk;

    dlat_cap_state_e cap_state;
    logic [13:0] cap_rem;
    logic [16:0] cap_div;

    // logical track number, counted across volumes on the fixed drive
    always_comb begin
        next_lin = 15'(lcyl_in) * DLAT_LTRK_PER_CYL + 15'(lhead_in);
        if (fixed_drive_in) begin
            next_lin = next_lin + 15'(volume_in) * DLAT_VOL_TRACKS;
        end
    end

    assign heads = fixed_drive_in ? DLAT_FX_HEADS : DLAT_RM_HEADS;
    assign positions = fixed_drive_in ? DLAT_FX_POS : DLAT_RM_POS;

    // physical address, overflowing across cylinders
    always_comb begin
        next_alt = even_defect_in & odd_defect_in;
        next_alt_err = even_defect_in ^ odd_defect_in;
        if (next_alt) begin
            next_pcyl = alt_pcyl_in;
            next_phead = alt_phead_in;
        end else begin
            next_pcyl = 10'(next_lin / 15'(heads));
            next_phead = 5'(next_lin % 15'(heads));
        end
    end

    // halftrack and position within it
    always_comb begin
        odd_index = record_in - even_last_rec_in;
        case (cmd_in)
            DLAT_CMD_HOME: begin
                next_odd = odd_half_sel_in;
                next_slot = DLAT_SLOT_HOME;
            end
            DLAT_CMD_DESC: begin
                next_odd = odd_half_sel_in;
                next_slot = DLAT_SLOT_DESC;
            end
            default: begin
                next_odd = record_in > even_last_rec_in;
                if (next_odd) begin
                    next_slot = 7'(odd_index) + DLAT_SLOT_DESC;
                end else begin
                    next_slot = 7'(record_in) + DLAT_SLOT_DESC;
                end
            end
        endcase
    end

    // refused addresses
    always_comb begin
        next_addr_err = 1'b0;
        if (lcyl_in > DLAT_LCYL_MAX) begin
            next_addr_err = 1'b1;
        end
        if (lhead_in > DLAT_LHEAD_MAX) begin
            next_addr_err = 1'b1;
        end
        if (next_pcyl >= positions || next_phead >= heads) begin
            next_addr_err = 1'b1;
        end
        if (cmd_in == DLAT_CMD_DATA) begin
            // record 0 is reached only by its own command
            if (record_in == 8'h00) begin
                next_addr_err = 1'b1;
            end
            if (record_in > DLAT_MAX_REC) begin
                next_addr_err = 1'b1;
            end
            if (even_last_rec_in > DLAT_HALF_MAX) begin
                next_addr_err = 1'b1;
            end
            if (next_odd && odd_index > DLAT_HALF_MAX) begin
                next_addr_err = 1'b1;
            end
        end
    end

    // microcode view: halftracks and six-head cylinders
    always_comb begin
        phys_trk = 16'(next_pcyl) * 16'(heads) + 16'(next_phead);
        next_uc_track = {phys_trk[14:0], next_odd};
        next_uc_cyl = 12'(next_pcyl) * (fixed_drive_in ?
            DLAT_UC_FX_PER_POS : DLAT_UC_RM_PER_POS)
            + 12'(next_phead / DLAT_UC_HEADS);
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= req_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pcyl_out <= 10'h000;
            phead_out <= 5'h00;
            odd_half_out <= 1'b0;
            slot_out <= 7'h00;
            alt_used_out <= 1'b0;
            addr_err_out <= 1'b0;
            alt_err_out <= 1'b0;
            uc_cyl_out <= 12'h000;
            uc_track_out <= 16'h0000;
        end else if (req_in) begin
            pcyl_out <= next_pcyl;
            phead_out <= next_phead;
            odd_half_out <= next_odd;
            slot_out <= next_slot;
            alt_used_out <= next_alt;
            addr_err_out <= next_addr_err | next_alt_err;
            alt_err_out <= next_alt_err;
            uc_cyl_out <= next_uc_cyl;
            uc_track_out <= next_uc_track;
        end
    end

    // halftrack capacity by repeated subtraction, one step a cycle
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cap_state <= DLAT_CAP_IDLE;
            cap_rem <= 14'h0000;
            cap_div <= 17'h00000;
            cap_records_out <= 6'h00;
            cap_busy_out <= 1'b0;
            cap_done_out <= 1'b0;
        end else begin
            cap_done_out <= 1'b0;
            case (cap_state)
                DLAT_CAP_IDLE: begin
                    if (cap_start_in) begin
                        cap_rem <= DLAT_HALF_CAP;
                        cap_div <= ((key_length_bytes_in == 8'h00) ?
                            DLAT_OVH_NOKEY : DLAT_OVH_KEY)
                            + 17'(key_length_bytes_in)
                            + 17'(data_length_bytes_in);
                        cap_records_out <= 6'h00;
                        cap_busy_out <= 1'b1;
                        cap_state <= DLAT_CAP_RUN;
                    end
                end
                DLAT_CAP_RUN: begin
                    if (17'(cap_rem) >= cap_div) begin
                        cap_rem <= cap_rem - 14'(cap_div);
                        cap_records_out <= cap_records_out + 6'h01;
                    end else begin
                        // remainder dropped: whole records only
                        cap_busy_out <= 1'b0;
                        cap_done_out <= 1'b1;
                        cap_state <= DLAT_CAP_IDLE;
                    end
                end
                default: begin
                    cap_state <= DLAT_CAP_IDLE;
                    cap_busy_out <= 1'b0;
                end
            endcase
        end
    end

    default clocking dlat_cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    chk_lcyl_refuse: assert property (
        req_in && lcyl_in > DLAT_LCYL_MAX |=> done_out && addr_err_out)
        else $error("logical cylinder above d1 not refused");

    chk_lhead_refuse: assert property (
        req_in && lhead_in > DLAT_LHEAD_MAX |=> addr_err_out)
        else $error("logical head above 13 not refused");

    chk_rm_overflow: assert property (
        req_in && !fixed_drive_in && !even_defect_in && !odd_defect_in
        |=> pcyl_out == 10'((15'($past(lcyl_in)) * 15'h014
            + 15'($past(lhead_in))) / 15'h00c))
        else $error("removable cylinder overflow wrong");

    chk_pos_limit: assert property (
        done_out && !addr_err_out && !alt_used_out
        |-> pcyl_out < ($past(fixed_drive_in) ? 10'h230 : 10'h15e))
        else $error("physical cylinder beyond access positions");

    chk_home_slot: assert property (
        req_in && cmd_in == DLAT_CMD_HOME
        |=> slot_out == 7'h00 && odd_half_out == $past(odd_half_sel_in))
        else $error("home address command misplaced");

    chk_odd_select: assert property (
        req_in && cmd_in == DLAT_CMD_DATA
        && record_in > even_last_rec_in |=> odd_half_out)
        else $error("record past even halftrack not on odd half");

    chk_alt_pair: assert property (
        req_in && (even_defect_in != odd_defect_in)
        |=> alt_err_out && !alt_used_out)
        else $error("single defective halftrack accepted");

    chk_uc_parity: assert property (
        done_out |-> uc_track_out[0] == odd_half_out)
        else $error("microcode track parity differs from halftrack");

    chk_cap_bound: assert property (
        cap_start_in && cap_state == DLAT_CAP_IDLE
        |=> cap_busy_out ##[1:60] cap_done_out)
        else $error("capacity not finished in time");

    chk_cap_trunc: assert property (
        cap_done_out |-> 23'(cap_records_out) * 23'(cap_div)
            <= 23'h002157
        && (23'(cap_records_out) + 23'h1) * 23'(cap_div) > 23'h002157)
        else $error("capacity quotient not truncated");

    chk_rm_head: assert property (
        req_in && !fixed_drive_in && !even_defect_in && !odd_defect_in
        |=> phead_out == 5'((15'($past(lcyl_in)) * 15'h014
            + 15'($past(lhead_in))) % 15'h00c))
        else $error("removable head overflow wrong");

    chk_fx_cyl: assert property (
        req_in && fixed_drive_in && !even_defect_in && !odd_defect_in
        |=> pcyl_out == 10'((15'($past(lcyl_in)) * 15'h014
            + 15'($past(volume_in)) * 15'h1068
            + 15'($past(lhead_in))) / 15'h01e))
        else $error("fixed drive cylinder wrong");

    chk_desc_slot: assert property (
        req_in && cmd_in == DLAT_CMD_DESC
        |=> slot_out == 7'h01 && odd_half_out == $past(odd_half_sel_in))
        else $error("descriptor command misplaced");

    chk_even_slot: assert property (
        req_in && cmd_in == DLAT_CMD_DATA
        && record_in <= even_last_rec_in
        |=> !odd_half_out && slot_out == 7'($past(record_in)) + 7'h01)
        else $error("even halftrack record misplaced");

    chk_rec_limit: assert property (
        req_in && cmd_in == DLAT_CMD_DATA && record_in > 8'h64
        |=> addr_err_out)
        else $error("record above track limit not refused");

    chk_rec_zero: assert property (
        req_in && cmd_in == DLAT_CMD_DATA && record_in == 8'h00
        |=> addr_err_out)
        else $error("descriptor reached by data command");

    chk_half_limit: assert property (
        req_in && cmd_in == DLAT_CMD_DATA && even_last_rec_in > 8'h32
        |=> addr_err_out)
        else $error("oversized halftrack not refused");

    chk_alt_swap: assert property (
        req_in && even_defect_in && odd_defect_in
        |=> alt_used_out && pcyl_out == $past(alt_pcyl_in)
        && phead_out == $past(alt_phead_in))
        else $error("alternate track not substituted");

    chk_uc_rm_cyl: assert property (
        done_out && !$past(fixed_drive_in)
        |-> uc_cyl_out == 12'(pcyl_out) * 12'h002
        + 12'(phead_out / 5'h06))
        else $error("removable microcode cylinder wrong");

    chk_done_pulse: assert property (
        done_out == $past(req_in))
        else $error("translation done not one cycle after request");

    chk_cap_key: assert property (
        cap_start_in && cap_state == DLAT_CAP_IDLE
        && key_length_bytes_in != 8'h00
        |=> cap_div == 17'h000f2 + 17'($past(key_length_bytes_in))
        + 17'($past(data_length_bytes_in)))
        else $error("keyed record overhead wrong");

    chk_cap_idle: assert property (
        cap_done_out |-> !cap_busy_out)
        else $error("capacity busy after done");

    cov_odd_data: cover property (
        done_out && odd_half_out && !addr_err_out);
    cov_alternate: cover property (done_out && alt_used_out);
    cov_fixed_drive: cover property (req_in && fixed_drive_in ##1
        done_out && !addr_err_out);
    cov_cap_key: cover property (cap_done_out
        && cap_div > 17'h000f2);
endmodule : dlat_translator

// [tb/dlat_host_model.sv]
`timescale 1ns/1ps
module dlat_host_model (
    input wire logic clk_in,
    output logic req_out,
    output dlat_pkg::dlat_cmd_e cmd_out,
    output logic fixed_out,
    output logic [1:0] volume_out,
    output logic [7:0] lcyl_out,
    output logic [4:0] lhead_out,
    output logic [7:0] record_out,
    output logic odd_sel_out,
    output logic [7:0] even_last_out,
    output logic even_defect_out,
    output logic odd_defect_out,
    output logic [9:0] alt_pcyl_out,
    output logic [4:0] alt_phead_out,
    output logic cap_start_out,
    output logic [7:0] kl_out,
    output logic [15:0] dl_out
);
    import dlat_pkg::*;
    initial begin
        {req_out, fixed_out, volume_out, lcyl_out, lhead_out} = '0;
        {record_out, odd_sel_out, even_last_out} = '0;
        {even_defect_out, odd_defect_out, cap_start_out} = '0;
        {kl_out, dl_out} = '0;
        cmd_out = DLAT_CMD_DATA;
        alt_pcyl_out = 10'h005;
        alt_phead_out = 5'h03;
    end
    // m = {fixed, odd halftrack, even defect, odd defect}
    task automatic xlate(input dlat_cmd_e c, input logic [1:0] v,
        input logic [7:0] cy, input logic [4:0] h, input logic [7:0] r,
        input logic [7:0] el, input logic [3:0] m);
        @(posedge clk_in);
        req_out <= 1'b1;
        cmd_out <= c;
        {fixed_out, odd_sel_out, even_defect_out, odd_defect_out} <= m;
        {volume_out, lcyl_out, lhead_out, record_out} <= {v, cy, h, r};
        even_last_out <= el;
        @(posedge clk_in);
        req_out <= 1'b0;
        // released address lines stop showing the last value
        {lcyl_out, lhead_out, record_out} <= ~{cy, h, r};
    endtask : xlate
    task automatic cap(input logic [7:0] k, input logic [15:0] d);
        @(posedge clk_in);
        cap_start_out <= 1'b1;
        {kl_out, dl_out} <= {k, d};
        @(posedge clk_in);
        cap_start_out <= 1'b0;
        {kl_out, dl_out} <= ~{k, d};
    endtask : cap
endmodule : dlat_host_model

// [tb/dlat_translator_bench.sv]
`timescale 1ns/1ps
module dlat_translator_bench;
    import dlat_pkg::*;
    logic clk, rst_n, req, fx, osel, edef, odef, cstart;
    logic done, ohalf, aused, aerr, alterr, cbusy, cdone;
    dlat_cmd_e cmd;
    logic [1:0] vol;
    logic [7:0] lcyl, rec, elast, kl;
    logic [4:0] lhead, aphead, phead;
    logic [9:0] apcyl, pcyl;
    logic [15:0] dl, uctrk;
    logic [6:0] slot;
    logic [11:0] uccyl;
    logic [5:0] crec;
    int error_cnt = 0;
    int tests_run = 0;
    dlat_host_model dlat_host_model_i (.clk_in(clk), .req_out(req),
        .cmd_out(cmd), .fixed_out(fx), .volume_out(vol), .lcyl_out(lcyl),
        .lhead_out(lhead), .record_out(rec), .odd_sel_out(osel),
        .even_last_out(elast), .even_defect_out(edef),
        .odd_defect_out(odef), .alt_pcyl_out(apcyl),
        .alt_phead_out(aphead), .cap_start_out(cstart), .kl_out(kl),
        .dl_out(dl));
    dlat_translator dlat_translator_i (.ref_clk_in(clk), .arst_n_in(rst_n),
        .req_in(req), .cmd_in(cmd), .fixed_drive_in(fx), .volume_in(vol),
        .lcyl_in(lcyl), .lhead_in(lhead), .record_in(rec),
        .odd_half_sel_in(osel), .even_last_rec_in(elast),
        .even_defect_in(edef), .odd_defect_in(odef), .alt_pcyl_in(apcyl),
        .alt_phead_in(aphead), .cap_start_in(cstart),
        .key_length_bytes_in(kl), .data_length_bytes_in(dl),
        .done_out(done), .pcyl_out(pcyl), .phead_out(phead),
        .odd_half_out(ohalf), .slot_out(slot), .alt_used_out(aused),
        .addr_err_out(aerr), .alt_err_out(alterr), .uc_cyl_out(uccyl),
        .uc_track_out(uctrk), .cap_busy_out(cbusy), .cap_done_out(cdone),
        .cap_records_out(crec));
    task automatic check(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic res(input logic [9:0] pc, input logic [4:0] ph,
        input logic oh, input logic [6:0] sl, input logic er);
        #1;
        check("done", 16'(done), 16'h0001);
        check("pcyl", 16'(pcyl), 16'(pc));
        check("phead", 16'(phead), 16'(ph));
        check("odd_half", 16'(ohalf), 16'(oh));
        check("slot", 16'(slot), 16'(sl));
        check("addr_err", 16'(aerr), 16'(er));
    endtask : res
    task automatic t_removable();
        dlat_host_model_i.xlate(DLAT_CMD_DATA, 2'h0, 8'h01, 5'h03, 8'h05,
            8'h0a, 4'h0);
        res(10'd1, 5'd11, 1'b0, 7'd6, 1'b0);
        check("uc_cyl", 16'(uccyl), 16'd3);
        check("uc_track", uctrk, 16'd46);
        @(posedge clk);
        #1;
        check("done_low", 16'(done), 16'h0000);
        dlat_host_model_i.xlate(DLAT_CMD_DATA, 2'h0, 8'h01, 5'h03, 8'h0c,
            8'h0a, 4'h0);
        res(10'd1, 5'd11, 1'b1, 7'd3, 1'b0);
        check("uc_track", uctrk, 16'd47);
        dlat_host_model_i.xlate(DLAT_CMD_DATA, 2'h0, 8'hd1, 5'h13, 8'h01,
            8'h01, 4'h0);
        res(10'd349, 5'd11, 1'b0, 7'd2, 1'b0);
        $display("removable done");
    endtask : t_removable
    task automatic t_fixed();
        dlat_host_model_i.xlate(DLAT_CMD_DATA, 2'h1, 8'hd1, 5'h13, 8'h01,
            8'h01, 4'h8);
        res(10'd279, 5'd29, 1'b0, 7'd2, 1'b0);
        check("uc_cyl", 16'(uccyl), 16'd1399);
        check("uc_track", uctrk, 16'd16798);
        $display("fixed done");
    endtask : t_fixed
    task automatic t_errors();
        logic [7:0] cy[5] = '{8'hd2, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [4:0] hd[5] = '{5'h00, 5'h14, 5'h00, 5'h00, 5'h00};
        logic [7:0] rc[5] = '{8'h01, 8'h01, 8'h00, 8'h65, 8'h01};
        logic [7:0] el[5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h33};
        for (int i = 0; i < 5; i++) begin
            dlat_host_model_i.xlate(DLAT_CMD_DATA, 2'h0, cy[i], hd[i],
                rc[i], el[i], 4'h0);
            #1;
            check("err_done", 16'(done), 16'h0001);
            check("refused", 16'(aerr), 16'h0001);
        end
        $display("errors done");
    endtask : t_errors
    task automatic t_areas();
        for (int i = 0; i < 4; i++) begin
            dlat_host_model_i.xlate(i[1] ? DLAT_CMD_DESC : DLAT_CMD_HOME,
                2'h0, 8'h00, 5'h00, 8'h00, 8'h00, {1'b0, i[0], 2'b00});
            res(10'd0, 5'd0, i[0], {6'h00, i[1]}, 1'b0);
        end
        $display("areas done");
    endtask : t_areas
    task automatic t_alt();
        dlat_host_model_i.xlate(DLAT_CMD_DATA, 2'h0, 8'h00, 5'h00, 8'h01,
            8'h01, 4'h3);
        res(10'd5, 5'd3, 1'b0, 7'd2, 1'b0);
        check("alt_used", 16'(aused), 16'h0001);
        dlat_host_model_i.xlate(DLAT_CMD_DATA, 2'h0, 8'h00, 5'h00, 8'h01,
            8'h01, 4'h2);
        #1;
        check("alt_err", 16'(alterr), 16'h0001);
        check("alt_refused", 16'(aerr), 16'h0001);
        $display("alternate done");
    endtask : t_alt
    task automatic t_cap();
        logic [7:0] k[4] = '{8'h00, 8'h08, 8'h00, 8'hff};
        logic [15:0] d[4] = '{16'h0100, 16'h0000, 16'h0000, 16'hffff};
        int q;
        for (int i = 0; i < 4; i++) begin
            q = 8535 / ((k[i] == 0 ? 167 : 242) + k[i] + d[i]);
            dlat_host_model_i.cap(k[i], d[i]);
            #1;
            check("cap_busy", 16'(cbusy), 16'h0001);
            for (int n = 0; n < 60 && cdone !== 1'b1; n++) begin
                @(posedge clk);
                #1;
            end
            check("cap_done", 16'(cdone), 16'h0001);
            check("cap_rec", 16'(crec), 16'(q));
            check("cap_idle", 16'(cbusy), 16'h0000);
        end
        $display("capacity done");
    endtask : t_cap
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_removable();
        t_fixed();
        t_errors();
        t_areas();
        t_alt();
        t_cap();
        complete_run();
    end
endmodule : dlat_translator_bench
